/* File: include/sdwl_regs.svh */
`ifndef SDWL_REGS_SVH
`define SDWL_REGS_SVH
`define SDWL_WORD_W    16
`define SDWL_CODE_MID  16'h8000
`define SDWL_CODE_MIN  16'h0000
`define SDWL_SHIFT_RST 16'h0000
`endif

/* File: include/sdwl_pkg.sv */
`default_nettype none
`include "sdwl_regs.svh"
package sdwl_pkg;
   typedef logic [`SDWL_WORD_W-1:0] sdwl_word_t;
   typedef struct packed {
      logic chipSelect_n;
      logic loadStrobe;
      logic clearLevelSelect;
   } sdwl_pins_t;
endpackage
`default_nettype wire

/* File: hdl/sdwl_word_loader.sv */
// Behaviour
// - Chip select low: shift on rising clock.
// - Chip select high: serial pins ignored.
// - Serial output driven only while selected.
// - Load rising edge copies input register.
// - Repeated loads without new data: no change.
// - Select rising with clock low shifts once.
// - Byte mode: select high pauses, contents kept.
// - Continuous mode shifts in and out forever.
// - Load takes the last sixteen shifted bits.
// - Prior contents shift out, MSB first.
// - Reset is asynchronous level, overrides loads.
// - Reset with select high gives mid-scale.
// - Reset with select low gives min-scale.
// - Minimum code is all sixteen zeros.
// - Select change during reset follows code.
`timescale 1ns/1ps
`default_nettype none
`include "sdwl_regs.svh"
module sdwl_word_loader (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 clkEn,
   input  wire logic                 serialClk,
   input  wire logic                 chipSelect_n,
   input  wire logic                 serialIn,
   input  wire logic                 loadStrobe,
   input  wire logic                 clearLevelSelect,
   output var  sdwl_pkg::sdwl_word_t analogOutputCode,
   output var  logic                 serialOut,
   output var  logic                 serialOutEn
);

   function automatic sdwl_pkg::sdwl_word_t clearCode(input logic midScale);
      clearCode = midScale ? `SDWL_CODE_MID : `SDWL_CODE_MIN;
   endfunction

   logic                 shiftClk;
   logic                 presetPending_r;
   logic                 shiftTgl_r;
   sdwl_pkg::sdwl_word_t shiftReg_r;
   sdwl_pkg::sdwl_word_t presetWord;
   logic                 resetSel_r;

   sdwl_pkg::sdwl_pins_t pinMeta_r;
   sdwl_pkg::sdwl_pins_t pinSync_r;
   logic                 rstMeta_r;
   logic                 rstSync_r;
   logic                 tglMeta_r;
   logic                 tglSync_r;
   logic                 tglSeen_r;
   logic                 loadSeen_r;
   logic                 tglChange;
   logic                 loadRise;
   sdwl_pkg::sdwl_word_t mirror_r;
   sdwl_pkg::sdwl_word_t mirror_nxt;
   sdwl_pkg::sdwl_word_t conv_r;
   sdwl_pkg::sdwl_word_t conv_nxt;
   logic                 serialOut_r;
   logic                 serialOutEn_r;

   // The shift clock is held high while deselected, so a select rising with the
   // serial clock low makes one more edge, exactly like the pin behaviour.
   assign shiftClk = serialClk | chipSelect_n;

   // The clear level is static once reset has released, so it is read as a constant.
   assign presetWord = clearCode(resetSel_r);

   // The first shift after reset starts from the clear code instead of zero.
   always_ff @(posedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         presetPending_r <= 1'b1;
      end else begin
         presetPending_r <= 1'b0;
      end
   end

   always_ff @(posedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         shiftReg_r <= `SDWL_SHIFT_RST;
      end else if (presetPending_r) begin
         shiftReg_r <= {presetWord[`SDWL_WORD_W-2:0], serialIn};
      end else begin
         shiftReg_r <= {shiftReg_r[`SDWL_WORD_W-2:0], serialIn};
      end
   end

   // Each shift toggles this flag; the word is stable when the toggle is seen.
   always_ff @(posedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         shiftTgl_r <= 1'b0;
      end else begin
         shiftTgl_r <= ~shiftTgl_r;
      end
   end

   // The pin synchroniser keeps running in reset so a clear level change is followed.
   always_ff @(posedge clk) begin
      if (clkEn) begin
         pinMeta_r <= '{chipSelect_n, loadStrobe, clearLevelSelect};
         pinSync_r <= pinMeta_r;
      end
   end

   // Assertion is immediate, release is synchronised to the system clock.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else if (clkEn) begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tglMeta_r <= 1'b0;
         tglSync_r <= 1'b0;
         tglSeen_r <= 1'b0;
      end else if (clkEn) begin
         tglMeta_r <= shiftTgl_r;
         tglSync_r <= tglMeta_r;
         tglSeen_r <= tglSync_r;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         loadSeen_r <= 1'b0;
      end else if (clkEn) begin
         loadSeen_r <= pinSync_r.loadStrobe;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn && !rstSync_r) begin
         resetSel_r <= pinSync_r.clearLevelSelect;
      end
   end

   assign tglChange = tglSync_r ^ tglSeen_r;
   assign loadRise  = pinSync_r.loadStrobe & ~loadSeen_r;

   always_comb begin
      mirror_nxt = mirror_r;
      if (!rstSync_r) begin
         mirror_nxt = clearCode(pinSync_r.clearLevelSelect);
      end else if (tglChange) begin
         mirror_nxt = shiftReg_r;
      end
   end

   // A load in the same cycle as a fresh capture takes the fresh word.
   always_comb begin
      conv_nxt = conv_r;
      if (!rstSync_r) begin
         conv_nxt = clearCode(pinSync_r.clearLevelSelect);
      end else if (loadRise) begin
         conv_nxt = mirror_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn) begin
         mirror_r <= mirror_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn) begin
         conv_r <= conv_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn) begin
         serialOut_r <= mirror_nxt[`SDWL_WORD_W-1];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serialOutEn_r <= 1'b0;
      end else if (clkEn) begin
         serialOutEn_r <= ~pinSync_r.chipSelect_n;
      end
   end

   assign analogOutputCode = conv_r;
   assign serialOut        = serialOut_r;
   assign serialOutEn      = serialOutEn_r;

   sequence sLoadTaken;
      clkEn && rstSync_r && loadRise;
   endsequence

   sequence sIdle;
      clkEn && rstSync_r && !loadRise;
   endsequence

   sequence sSelected;
      clkEn && !pinSync_r.chipSelect_n;
   endsequence

   sequence sDeselected;
      clkEn && pinSync_r.chipSelect_n;
   endsequence

   sequence sCapture;
      clkEn && rstSync_r && tglChange;
   endsequence

   sequence sResetRelease;
      clkEn && $past(clkEn) && $rose(rstSync_r);
   endsequence

   AST_LOAD_COPIES: assert property (
      @(posedge clk) disable iff (!reset_n)
      sLoadTaken |=> (analogOutputCode == mirror_r))
      else $error("load did not copy the input register");

   AST_LOAD_HOLD: assert property (
      @(posedge clk) disable iff (!reset_n)
      sIdle |=> $stable(analogOutputCode))
      else $error("converter code moved without a load");

   AST_CAPTURE: assert property (
      @(posedge clk) disable iff (!reset_n)
      sCapture |=> (mirror_r == $past(shiftReg_r)))
      else $error("shifted word not captured");

   AST_OUT_ON: assert property (
      @(posedge clk) disable iff (!reset_n)
      sSelected |=> serialOutEn)
      else $error("serial output not enabled while selected");

   AST_OUT_OFF: assert property (
      @(posedge clk) disable iff (!reset_n)
      sDeselected |=> !serialOutEn)
      else $error("serial output still enabled while deselected");

   AST_OUT_MSB: assert property (
      @(posedge clk) disable iff (!reset_n)
      $past(clkEn) |-> (serialOut == mirror_r[`SDWL_WORD_W-1]))
      else $error("serial output is not the register top bit");

   AST_CS_IGNORE: assert property (
      @(posedge clk) disable iff (!reset_n)
      (clkEn && pinSync_r.chipSelect_n) [*6] |-> !tglChange)
      else $error("shift seen while deselected");

   AST_RESET_MID: assert property (
      @(posedge clk) disable iff (!reset_n)
      sResetRelease ##0 $past(pinSync_r.clearLevelSelect)
      |-> (analogOutputCode == `SDWL_CODE_MID) && (mirror_r == `SDWL_CODE_MID))
      else $error("mid-scale clear code missing");

   AST_RESET_MIN: assert property (
      @(posedge clk) disable iff (!reset_n)
      sResetRelease ##0 !$past(pinSync_r.clearLevelSelect)
      |-> (analogOutputCode == `SDWL_CODE_MIN) && (mirror_r == `SDWL_CODE_MIN))
      else $error("min-scale clear code missing");

   AST_RESET_OVERRIDE: assert property (
      @(posedge clk) disable iff (!reset_n)
      (clkEn && !rstSync_r)
      |=> (analogOutputCode == clearCode($past(pinSync_r.clearLevelSelect))))
      else $error("clear code not forced during reset");

   AST_SHIFT: assert property (
      @(posedge shiftClk) disable iff (!reset_n)
      !presetPending_r |=> (shiftReg_r[`SDWL_WORD_W-1:1] == $past(shiftReg_r[`SDWL_WORD_W-2:0]))
      && (shiftTgl_r != $past(shiftTgl_r)))
      else $error("shift register did not shift");

   AST_PRESET: assert property (
      @(posedge shiftClk) disable iff (!reset_n)
      presetPending_r |=> (shiftReg_r[`SDWL_WORD_W-1:1] == $past(presetWord[`SDWL_WORD_W-2:0])))
      else $error("first shift did not start from the clear code");

   AST_LOAD_SAME: assert property (
      @(posedge clk) disable iff (!reset_n)
      sLoadTaken ##0 (mirror_nxt == analogOutputCode) |=> $stable(analogOutputCode))
      else $error("repeated load changed the converter code");

   AST_LOAD_UPDATE: assert property (
      @(posedge clk) disable iff (!reset_n)
      sLoadTaken ##0 (mirror_nxt != analogOutputCode) |=> $changed(analogOutputCode))
      else $error("load with new data left the converter code");

   AST_OUT_FOLLOW: assert property (
      @(posedge clk) disable iff (!reset_n)
      sCapture |=> (serialOut == $past(shiftReg_r[`SDWL_WORD_W-1])))
      else $error("serial output does not follow the new top bit");

   AST_NO_CAPTURE: assert property (
      @(posedge clk) disable iff (!reset_n)
      (clkEn && rstSync_r && pinSync_r.chipSelect_n) [*6] |=> $stable(mirror_r))
      else $error("input register changed while deselected");

endmodule
`default_nettype wire

/* File: bench/sdwl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdwl_host_model (
   output var logic serialClk,
   output var logic chipSelect_n,
   output var logic serialIn,
   input  wire logic serialOut,
   input  wire logic serialOutEn
);
   // A released output line reads as the inverse of its last value.
   wire logic lineLevel;
   assign lineLevel = serialOutEn ? serialOut : ~serialOut;
   initial begin
      serialClk = 1'b1;
      chipSelect_n = 1'b1;
      serialIn = 1'b0;
   end
   // Sends n bits MSB first and collects what the far end shifts out.
   task automatic send(input sdwl_pkg::sdwl_word_t w, input int n, input logic endLow,
                       output sdwl_pkg::sdwl_word_t seen, output logic en);
      #1;
      seen = 16'h0000;
      chipSelect_n = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         serialClk = 1'b0;
         serialIn = w[i];
         #80;
         seen = {seen[14:0], lineLevel};
         serialClk = 1'b1;
         #80;
      end
      en = serialOutEn;
      if (endLow) begin
         serialClk = 1'b0;
         serialIn = 1'b1;
         #80;
      end
      chipSelect_n = 1'b1;
      #80;
      serialClk = 1'b1;
      serialIn = ~serialIn;
      #80;
      #1;
   endtask
   // Clocks the link while deselected, with changing data.
   task automatic idle(input int n);
      #1;
      for (int i = 0; i < n; i++) begin
         serialClk = 1'b0;
         serialIn = ~serialIn;
         #80;
         serialClk = 1'b1;
         #80;
      end
      #1;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                 clk;
   logic                 reset_n;
   logic                 loadStrobe;
   logic                 clearLevelSelect;
   wire logic            serialClk;
   wire logic            chipSelect_n;
   wire logic            serialIn;
   wire logic            serialOut;
   wire logic            serialOutEn;
   sdwl_pkg::sdwl_word_t analogOutputCode;
   sdwl_pkg::sdwl_word_t seen;
   logic                 en;
   int                   n_fail = 0;
   int                   total_checks = 0;

   sdwl_word_loader i_dut (.clk(clk), .reset_n(reset_n), .clkEn(1'b1),
      .serialClk(serialClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
      .loadStrobe(loadStrobe), .clearLevelSelect(clearLevelSelect),
      .analogOutputCode(analogOutputCode), .serialOut(serialOut),
      .serialOutEn(serialOutEn));
   sdwl_host_model i_host (.serialClk(serialClk), .chipSelect_n(chipSelect_n),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic load();
      @(posedge clk) loadStrobe <= 1'b1;
      repeat (5) @(posedge clk);
      loadStrobe <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic t_reset();
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("code", analogOutputCode, 16'h0000);
      check("enable", {15'h0, serialOutEn}, 16'h0000);
      reset_n <= 1'b0;
      clearLevelSelect <= 1'b1;
      loadStrobe <= 1'b1;
      repeat (6) @(posedge clk);
      check("code", analogOutputCode, 16'h8000);
      clearLevelSelect <= 1'b0;
      repeat (6) @(posedge clk);
      check("code", analogOutputCode, 16'h0000);
      clearLevelSelect <= 1'b1;
      repeat (6) @(posedge clk);
      check("code", analogOutputCode, 16'h8000);
      loadStrobe <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("code", analogOutputCode, 16'h8000);
      $display("reset test done");
   endtask

   task automatic t_word();
      i_host.send(16'hA5C3, 16, 1'b0, seen, en);
      check("daisy", seen, 16'h8000);
      check("enable", {15'h0, en}, 16'h0001);
      check("enable", {15'h0, serialOutEn}, 16'h0000);
      load();
      check("code", analogOutputCode, 16'hA5C3);
      load();
      check("code", analogOutputCode, 16'hA5C3);
      $display("word test done");
   endtask

   task automatic t_byte();
      i_host.send(16'h003C, 8, 1'b0, seen, en);
      check("daisy", {8'h00, seen[7:0]}, 16'h00A5);
      i_host.idle(5);
      i_host.send(16'h0096, 8, 1'b0, seen, en);
      check("daisy", {8'h00, seen[7:0]}, 16'h00C3);
      load();
      check("code", analogOutputCode, 16'h3C96);
      $display("byte test done");
   endtask

   task automatic t_extra();
      i_host.send(16'h1234, 16, 1'b1, seen, en);
      check("daisy", seen, 16'h3C96);
      load();
      check("code", analogOutputCode, 16'h2469);
      i_host.send(16'h00FF, 8, 1'b0, seen, en);
      check("daisy", {8'h00, seen[7:0]}, 16'h0024);
      load();
      check("code", analogOutputCode, 16'h69FF);
      $display("extra shift test done");
   endtask

   initial begin
      reset_n = 1'b0;
      loadStrobe = 1'b0;
      clearLevelSelect = 1'b0;
      t_reset();
      t_word();
      t_byte();
      t_extra();
      final_report();
   end

   initial begin
      #200000;
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
